// *** rtl/edge_event_counter_map.svh ***
/*
 * offsets, field positions, reset values and limits of the edge event counter.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef EDGE_EVENT_COUNTER_MAP_SVH
`define EDGE_EVENT_COUNTER_MAP_SVH

// register byte offsets
`define EEC_CTRL_OFS      12'h000
`define EEC_TARGET_OFS    12'h004
`define EEC_LOAD_OFS      12'h008
`define EEC_COUNT_OFS     12'h00C
`define EEC_STATUS_OFS    12'h010

// control field positions
`define EEC_CTRL_DOWN_BIT   0
`define EEC_CTRL_LATCH_BIT  1
`define EEC_CTRL_CEDGE_LO   2
`define EEC_CTRL_CEDGE_HI   3
`define EEC_CTRL_REDGE_BIT  4
`define EEC_CTRL_SWRST_BIT  5

// reset values
`define EEC_CTRL_RST      6'h00
`define EEC_TARGET_RST    14'h0000
`define EEC_LOAD_RST      14'h0000

// count range
`define EEC_COUNT_MAX     14'd9999

// axi response codes
`define EEC_RESP_OKAY     2'b00
`define EEC_RESP_SLVERR   2'b10

`endif

// *** rtl/edge_event_counter_pkg.sv ***
/*
 * types shared by the edge event counter files.
 * assumes the map header sits beside it in rtl/.
 */
`include "edge_event_counter_map.svh"

package edge_event_counter_pkg;

    // which count input transitions are counted
    typedef enum logic [1:0] {
        CEDGE_BOTH,
        CEDGE_RISE,
        CEDGE_FALL
    } count_edge_e;

    // count value in the range zero to the upper bound
    typedef logic [13:0] count_t;

    // configuration that steers the counter core
    typedef struct packed {
        logic        count_down;
        logic        latch_en;
        logic [1:0]  count_edge;
        logic        reset_fall;
        count_t      target;
        count_t      load;
    } counter_cfg_s;

    // qualified digital input with its error flag
    typedef struct packed {
        logic level;
        logic err;
    } digital_in_s;

endpackage : edge_event_counter_pkg

// *** rtl/edge_detect.sv ***
/*
 * edge detector for one digital input with error qualifier.
 * assumes the input is synchronous to aclk.
 */
`timescale 1ns/1ns

module edge_detect
    import edge_event_counter_pkg::*;
(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // input signal
    input  wire digital_in_s  sig,
    // edge pulses, blocked while error
    output logic              rise,
    output logic              fall
);

    logic prev_r;
    logic seen_r;

    // previous level; first sample after reset gives no edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            prev_r <= sig.level;
            seen_r <= 1'b1;
        end
    end

    // edges qualified by the error flag
    assign rise = seen_r & ~sig.err & sig.level & ~prev_r;
    assign fall = seen_r & ~sig.err & ~sig.level & prev_r;

endmodule : edge_detect

// *** rtl/edge_event_counter.sv ***
/*
 * up/down event counter with target match, load value and reload input,
 * reached over an axi4-lite register slave.
 * assumes count and reload inputs synchronous to aclk, one write and one read at a time.
 */
// Functional notes
// - direction up adds one per qualifying count edge.
// - direction down subtracts one per qualifying count edge.
// - match output asserts when count equals target.
// - qualifying reload event loads the load value; match then follows load against target.
// - target is programmable from zero to 9,999.
// - load value 0..9,999 copied into count at power-up and reload.
// - latching keeps match asserted until a reload event.
// - non-latching match only while count equals target.
// - count edge select: both, rising only, or falling only.
// - reload edge select: rising or falling transition.
// - count is readable and always within zero to 9,999.
// - incrementing at 9,999 wraps to zero.
// - count input error blocks counting, reload still works.
// - reload input error blocks reload, counting still works.
// - match depends only on count and target, never on errors.
// - no error indication is created or passed on.
`timescale 1ns/1ns
`include "edge_event_counter_map.svh"

module edge_event_counter
    import edge_event_counter_pkg::*;
(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // axi4-lite write address
    input  wire logic [11:0]  s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    // axi4-lite write response
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0]  s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    // axi4-lite read data
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // digital inputs with error qualifiers
    input  wire logic         count_pulse_in,
    input  wire logic         count_pulse_err,
    input  wire logic         reload_in,
    input  wire logic         reload_err,
    // match output
    output logic              match_out
);

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [5:0]   ctrl_r;
    count_t       target_r;
    count_t       load_r;
    count_t       count_r;
    count_t       count_nxt;
    logic         match_r;
    logic         match_nxt;
    logic         init_r;
    logic         swrst_r;
    counter_cfg_s cfg;

    // configuration view of the control, target and load registers
    assign cfg.count_down = ctrl_r[`EEC_CTRL_DOWN_BIT];
    assign cfg.latch_en   = ctrl_r[`EEC_CTRL_LATCH_BIT];
    assign cfg.count_edge = ctrl_r[`EEC_CTRL_CEDGE_HI:`EEC_CTRL_CEDGE_LO];
    assign cfg.reset_fall = ctrl_r[`EEC_CTRL_REDGE_BIT];
    assign cfg.target     = target_r;
    assign cfg.load       = load_r;

    ////////////////////////////////////////////////////////////////////////////
    // write channel

    logic        aw_held_r;
    logic        w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        aw_take;
    logic        w_take;
    logic        wr_go;
    logic        wr_ctrl;
    logic        wr_target;
    logic        wr_load;
    logic        wr_ok;
    count_t      wr_val;
    logic [5:0]  ctrl_wval;
    logic        aw_held_nxt;
    logic        w_held_nxt;
    logic        bvalid_nxt;
    count_t      target_nxt;
    logic        latch_nxt;

    // accept address and data in either order, answer once both are in
    assign aw_take     = s_axi_awvalid & s_axi_awready;
    assign w_take      = s_axi_wvalid & s_axi_wready;
    assign wr_go       = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign aw_held_nxt = aw_take | (aw_held_r & ~wr_go);
    assign w_held_nxt  = w_take | (w_held_r & ~wr_go);
    assign bvalid_nxt  = wr_go | (s_axi_bvalid & ~s_axi_bready);

    // write decode; values above the upper bound are refused
    assign wr_val    = wdata_r[13:0];
    assign wr_ctrl   = wr_go & (awaddr_r == `EEC_CTRL_OFS) & wstrb_r[0];
    assign wr_target = wr_go & (awaddr_r == `EEC_TARGET_OFS) & (&wstrb_r[1:0]) & (wdata_r <= 32'h0000_270F);
    assign wr_load   = wr_go & (awaddr_r == `EEC_LOAD_OFS) & (&wstrb_r[1:0]) & (wdata_r <= 32'h0000_270F);
    assign wr_ok     = wr_ctrl | wr_target | wr_load;
    assign ctrl_wval = (wdata_r[3:2] == 2'b11) ? {wdata_r[5:4], 2'b00, wdata_r[1:0]} : wdata_r[5:0];

    // settings as they stand after this edge, so match never lags a write
    assign target_nxt = wr_target ? wr_val : target_r;
    assign latch_nxt  = wr_ctrl ? ctrl_wval[`EEC_CTRL_LATCH_BIT] : cfg.latch_en;

    // write handshake holding registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 12'h000;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            // ready straight from a flop, low while a word is held or answered
            s_axi_awready <= ~aw_held_nxt & ~bvalid_nxt;
            s_axi_wready  <= ~w_held_nxt & ~bvalid_nxt;
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= {s_axi_awaddr[11:2], 2'b00};
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EEC_RESP_OKAY;
        end else begin
            s_axi_bvalid <= bvalid_nxt;
            if (wr_go) s_axi_bresp <= wr_ok ? `EEC_RESP_OKAY : `EEC_RESP_SLVERR;
        end
    end

    // configuration registers; software reload bit is a self-clearing pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r   <= `EEC_CTRL_RST;
            target_r <= `EEC_TARGET_RST;
            load_r   <= `EEC_LOAD_RST;
            swrst_r  <= 1'b0;
        end else begin
            swrst_r <= wr_ctrl & wdata_r[`EEC_CTRL_SWRST_BIT];
            if (wr_ctrl) ctrl_r <= {1'b0, ctrl_wval[4:0]};
            if (wr_target) target_r <= wr_val;
            if (wr_load) load_r <= wr_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel

    logic        ar_take;
    logic [11:0] raddr;
    logic [31:0] rd_mux;
    logic        rd_hit;
    logic        rvalid_nxt;

    assign ar_take       = s_axi_arvalid & s_axi_arready;
    assign rvalid_nxt    = ar_take | (s_axi_rvalid & ~s_axi_rready);
    assign raddr         = {s_axi_araddr[11:2], 2'b00};

    // read decode; unmapped addresses read zero with slverr
    assign rd_hit = (raddr == `EEC_CTRL_OFS) | (raddr == `EEC_TARGET_OFS) | (raddr == `EEC_LOAD_OFS)
                  | (raddr == `EEC_COUNT_OFS) | (raddr == `EEC_STATUS_OFS);
    assign rd_mux = (raddr == `EEC_CTRL_OFS)   ? {26'd0, ctrl_r} :
                    (raddr == `EEC_TARGET_OFS) ? {18'd0, target_r} :
                    (raddr == `EEC_LOAD_OFS)   ? {18'd0, load_r} :
                    (raddr == `EEC_COUNT_OFS)  ? {18'd0, count_r} :
                    (raddr == `EEC_STATUS_OFS) ? {31'd0, match_r} : 32'h0000_0000;

    // read data register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `EEC_RESP_OKAY;
        end else begin
            s_axi_rvalid  <= rvalid_nxt;
            s_axi_arready <= ~rvalid_nxt; // one read at a time
            if (ar_take) begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `EEC_RESP_OKAY : `EEC_RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input edge detection

    digital_in_s cnt_in;
    digital_in_s rld_in;
    logic        cnt_rise;
    logic        cnt_fall;
    logic        rld_rise;
    logic        rld_fall;

    assign cnt_in = '{level: count_pulse_in, err: count_pulse_err};
    assign rld_in = '{level: reload_in, err: reload_err};

    edge_detect u_cnt_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sig     (cnt_in),
        .rise    (cnt_rise),
        .fall    (cnt_fall)
    );

    edge_detect u_rld_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sig     (rld_in),
        .rise    (rld_rise),
        .fall    (rld_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // counter core

    logic   count_ev;
    logic   reload_ev;
    logic   hw_reload;
    count_t count_up;
    count_t count_dn;
    count_t count_step;
    logic   eq_next;

    // qualifying count edge by selection
    assign count_ev = (cfg.count_edge == CEDGE_BOTH) ? (cnt_rise | cnt_fall) :
                      (cfg.count_edge == CEDGE_RISE) ? cnt_rise : cnt_fall;
    // qualifying reload edge by selection
    assign hw_reload = cfg.reset_fall ? rld_fall : rld_rise;
    assign reload_ev = hw_reload | swrst_r;

    // stepped values with wrap at both ends
    assign count_up   = (count_r >= `EEC_COUNT_MAX) ? 14'd0 : count_r + 14'd1;
    assign count_dn   = (count_r == 14'd0) ? `EEC_COUNT_MAX : count_r - 14'd1;
    assign count_step = cfg.count_down ? count_dn : count_up;

    // next count: power-up and reload load, reload beats count
    assign count_nxt = (init_r | reload_ev) ? cfg.load :
                       count_ev ? count_step : count_r;
    assign eq_next   = (count_nxt == target_nxt);

    // next match: latched or live compare, reload clears latch
    assign match_nxt = (reload_ev | init_r) ? eq_next :
                       latch_nxt ? (match_r | eq_next) : eq_next;

    // count and match registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_r  <= 1'b1;
            count_r <= 14'd0;
            match_r <= 1'b0;
        end else begin
            init_r  <= 1'b0;
            count_r <= count_nxt;
            match_r <= match_nxt;
        end
    end

    // match output straight from its flip-flop, no error path
    assign match_out = match_r;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_count_edge;
        count_ev && !reload_ev && !init_r;
    endsequence

    sequence s_reload;
        reload_ev && !init_r;
    endsequence

    a_up_increment: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_count_edge and !cfg.count_down && count_r != `EEC_COUNT_MAX)
        |=> count_r == $past(count_r) + 14'd1)
        else $error("up count did not add one");

    a_down_decrement: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_count_edge and cfg.count_down && count_r != 14'd0)
        |=> count_r == $past(count_r) - 14'd1)
        else $error("down count did not subtract one");

    a_match_equal: assert property (@(posedge aclk) disable iff (!aresetn)
        !init_r && count_r == target_r && !$past(init_r) |-> match_out)
        else $error("match low while count equals target");

    a_reload_loads: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reload |=> count_r == $past(load_r))
        else $error("reload did not load the load value");

    a_count_range: assert property (@(posedge aclk) disable iff (!aresetn)
        count_r <= `EEC_COUNT_MAX && target_r <= `EEC_COUNT_MAX)
        else $error("count or target out of range");

    a_up_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_count_edge and !cfg.count_down && count_r == `EEC_COUNT_MAX) |=> count_r == 14'd0)
        else $error("up wrap missed");

    a_down_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_count_edge and cfg.count_down && count_r == 14'd0) |=> count_r == `EEC_COUNT_MAX)
        else $error("down wrap missed");

    a_err_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        count_pulse_err && !reload_ev && !init_r |=> $stable(count_r))
        else $error("count moved during count input error");

    a_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        match_out && latch_nxt && !reload_ev && !init_r |=> match_out)
        else $error("latched match dropped without reload");

    a_nolatch_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg.latch_en && !init_r && !$past(init_r) && count_r != target_r |-> !match_out)
        else $error("unlatched match high off target");

endmodule : edge_event_counter

// *** tb/digital_source.sv ***
/*
 * model of the function blocks that feed the counter its two digital
 * inputs and their error flags.
 * assumes the bench calls its tasks just after a rising edge of aclk.
 */
`timescale 1ns/1ns

module digital_source (
    // clock
    input  wire logic aclk,
    // levels and error flags toward the counter
    output logic      count_pulse_in,
    output logic      count_pulse_err,
    output logic      reload_in,
    output logic      reload_err
);
    // all levels off and error free at power up
    initial begin
        count_pulse_in  = 1'b0;
        count_pulse_err = 1'b0;
        reload_in       = 1'b0;
        reload_err      = 1'b0;
    end

    ////////////////////////////////////////
    // level changes, each launched on a rising edge
    task tc;
        @(posedge aclk);
        count_pulse_in <= ~count_pulse_in;
    endtask : tc

    task tr;
        @(posedge aclk);
        reload_in <= ~reload_in;
    endtask : tr

    // both inputs change at one edge
    task both;
        @(posedge aclk);
        count_pulse_in <= ~count_pulse_in;
        reload_in      <= ~reload_in;
    endtask : both

    task err(input logic ce, input logic re);
        @(posedge aclk);
        count_pulse_err <= ce;
        reload_err      <= re;
    endtask : err
endmodule : digital_source

// *** tb/edge_event_counter_tb.sv ***
/*
 * self-checking bench of the edge event counter: axi4-lite register
 * tasks plus a digital source model on the count and reload inputs.
 * assumes the design package and map header from rtl/.
 */
`timescale 1ns/1ns
`include "edge_event_counter_map.svh"

module edge_event_counter_tb
    import edge_event_counter_pkg::*;
;
    localparam logic [11:0] CT = `EEC_CTRL_OFS;
    localparam logic [11:0] TG = `EEC_TARGET_OFS;
    localparam logic [11:0] LD = `EEC_LOAD_OFS;
    localparam logic [11:0] CN = `EEC_COUNT_OFS;
    localparam logic [11:0] ST = `EEC_STATUS_OFS;
    localparam logic [1:0]  OK = `EEC_RESP_OKAY;
    localparam logic [1:0]  SE = `EEC_RESP_SLVERR;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, match_out;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire         cin, cerr, rin, rerr;
    int          errors = 0, n_compared = 0;

    // 25 MHz clock
    always #20 aclk = ~aclk;

    digital_source src (.aclk(aclk), .count_pulse_in(cin), .count_pulse_err(cerr),
                        .reload_in(rin), .reload_err(rerr));

    edge_event_counter DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .count_pulse_in(cin), .count_pulse_err(cerr), .reload_in(rin), .reload_err(rerr),
        .match_out(match_out)
    );

    ////////////////////////////////////////
    // report and compare helpers
    task give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task hang(input string nm);
        errors++;
        $display("[FAIL] %s expected answer seen none", nm);
        give_verdict;
    endtask : hang

    ////////////////////////////////////////
    // axi4-lite master: write, then wait for the response
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (i == 20) hang("bvalid");
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
    endtask : wr

    // read one word and compare data and response
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int i;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (i == 20) hang("rvalid");
        chk($sformatf("rdata %h", a), e, rdata);
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
    endtask : rd

    task automatic mchk(input logic e);
        repeat (2) @(posedge aclk);
        chk("match_out", {31'h0, e}, {31'h0, match_out});
    endtask : mchk

    function automatic logic [31:0] cfg(logic dn, logic lt, count_edge_e ce, logic rf, logic sw);
        return {26'h0, sw, rf, ce, lt, dn};
    endfunction : cfg

    ////////////////////////////////////////
    // hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        hang("run end");
    end

    // main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CT, 32'h0000_0000, OK);
        rd(LD, 32'h0000_0000, OK);
        rd(CN, 32'h0000_0000, OK);
        rd(ST, 32'h0000_0001, OK);
        mchk(1'b1);
        $display("test reset values done");
        wr(TG, 32'h0000_2710, SE);
        wr(TG, 32'h0000_270F, OK);
        rd(TG, 32'h0000_270F, OK);
        wr(LD, 32'h0000_2710, SE);
        wr(CN, 32'h0000_0005, SE);
        wstrb <= 4'h1;
        wr(TG, 32'h0000_0001, SE);
        wstrb <= 4'hF;
        rd(TG, 32'h0000_270F, OK);
        rd(12'h100, 32'h0000_0000, SE);
        $display("test ranges done");
        wr(TG, 32'h0000_0000, OK);
        wr(LD, 32'h0000_270E, OK);
        for (int m = 0; m < 3; m++) begin
            wr(CT, cfg(0, 0, count_edge_e'(m), 0, 1), OK);
            rd(CN, 32'h0000_270E, OK);
            src.tc;
            rd(CN, (m == 2) ? 32'h0000_270E : 32'h0000_270F, OK);
            mchk(1'b0);
            src.tc;
            rd(CN, (m == 0) ? 32'h0000_0000 : 32'h0000_270F, OK);
            mchk(m == 0);
        end
        $display("test count edges done");
        wr(LD, 32'h0000_0001, OK);
        wr(CT, cfg(1, 0, CEDGE_BOTH, 0, 1), OK);
        src.tc;
        rd(CN, 32'h0000_0000, OK);
        mchk(1'b1);
        src.tc;
        rd(CN, 32'h0000_270F, OK);
        mchk(1'b0);
        $display("test count down done");
        wr(LD, 32'h0000_0005, OK);
        wr(TG, 32'h0000_0006, OK);
        wr(CT, cfg(0, 1, CEDGE_BOTH, 0, 1), OK);
        src.tc;
        src.tc;
        rd(CN, 32'h0000_0007, OK);
        mchk(1'b1);
        src.tr;
        rd(CN, 32'h0000_0005, OK);
        mchk(1'b0);
        wr(CT, cfg(0, 1, CEDGE_BOTH, 1, 0), OK);
        src.tc;
        src.tr;
        rd(CN, 32'h0000_0005, OK);
        src.tc;
        src.tr;
        rd(CN, 32'h0000_0006, OK);
        $display("test latch and reload done");
        wr(CT, cfg(0, 0, CEDGE_BOTH, 1, 0), OK);
        src.err(1, 0);
        src.tc;
        rd(CN, 32'h0000_0006, OK);
        mchk(1'b1);
        src.tr;
        rd(CN, 32'h0000_0005, OK);
        src.err(0, 1);
        src.tc;
        src.tr;
        src.tr;
        rd(CN, 32'h0000_0006, OK);
        mchk(1'b1);
        src.err(0, 0);
        src.tr;
        src.both;
        rd(CN, 32'h0000_0005, OK);
        $display("test errors and priority done");
        give_verdict;
    end
endmodule : edge_event_counter_tb
